// *** pxe_device.sv ***
`default_nettype none

module pxe_device (
  input wire logic core_clk,
  input wire logic reset_n,
  pxe_i2c_if.device bus,
  input wire pxe_pkg::pxe_byte_t port_i,
  output pxe_pkg::pxe_byte_t port_o,
  output pxe_pkg::pxe_byte_t port_oe_n,
  input wire logic addr_sel_bit0,
  input wire logic addr_sel_bit1,
  input wire logic addr_sel_bit2
);
  import pxe_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    pxe_dev_st_t st;
    logic primed;
    logic [1:0] warm;
    logic scl_d;
    logic sda_d;
    logic [2:0] bitc;
    logic got;
    logic rw;
    logic selected;
    logic master_ack;
    pxe_byte_t sh;
    pxe_byte_t tx;
    pxe_byte_t in_reg;
    pxe_byte_t out_reg;
    pxe_byte_t pol_reg;
    pxe_byte_t cfg_reg;
    logic [1:0] cmd;
    logic sda_oe_n;
    logic int_oe_n;
  } pxe_dev_state_t;

  localparam pxe_dev_state_t DEV_RST = '{st: D_IDLE, out_reg: OUTPUT_RST, pol_reg: POLARITY_RST,
                                         cfg_reg: CONFIG_RST, sda_oe_n: 1'b1, int_oe_n: 1'b1,
                                         scl_d: 1'b1, sda_d: 1'b1, default: '0};

  pxe_dev_state_t r;
  pxe_dev_state_t next_r;
  logic scl_s;
  logic sda_s;
  pxe_byte_t port_s;
  logic [2:0] addr_s;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  pxe_sync #(.W(13)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .d({bus.scl, bus.sda, port_i, addr_sel_bit2, addr_sel_bit1, addr_sel_bit0}),
    .q({scl_s, sda_s, port_s, addr_s})
  );

  // Register read mux; input port shows the captured pins with inversion
  function automatic pxe_byte_t read_reg(input pxe_dev_state_t s);
    case (s.cmd)
      REG_INPUT: read_reg = s.in_reg ^ s.pol_reg;
      REG_OUTPUT: read_reg = s.out_reg;
      REG_POLARITY: read_reg = s.pol_reg;
      default: read_reg = s.cfg_reg;
    endcase
  endfunction

  // Bus conditions, seen on synchronised levels
  assign scl_rise = scl_s & ~r.scl_d;
  assign scl_fall = ~scl_s & r.scl_d;
  assign start_cond = scl_s & r.scl_d & r.sda_d & ~sda_s;
  assign stop_cond = scl_s & r.scl_d & ~r.sda_d & sda_s;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.scl_d = scl_s;
    next_r.sda_d = sda_s;
    // Synchronisers show their reset ones for two cycles, so the reference
    // keeps following the pins until real levels have arrived
    next_r.warm = {r.warm[0], 1'b1};
    if (!r.primed)
    begin
      next_r.primed = r.warm[1];
      next_r.in_reg = port_s;
    end
    if (stop_cond)
    begin
      // Only our own transaction's stop clears the alert
      if (r.selected)
        next_r.in_reg = port_s;
      next_r.selected = 1'b0;
      next_r.got = 1'b0;
      next_r.st = D_IDLE;
      next_r.sda_oe_n = 1'b1;
    end
    else if (start_cond)
    begin
      // The command pointer is left alone across a restart
      next_r.st = D_ADDR;
      next_r.bitc = '0;
      next_r.got = 1'b0;
      next_r.sda_oe_n = 1'b1;
    end
    else if (scl_rise)
    begin
      next_r.sh = {r.sh[6:0], sda_s};
      next_r.bitc = r.bitc + 3'h1;
      case (r.st)
        D_ADDR, D_CMD, D_WDATA, D_RDATA:
          if (r.bitc == LAST_BIT)
            next_r.got = 1'b1;
        D_ADDR_ACK:
          // First read byte gets a fresh snapshot too
          if (r.rw)
            next_r.in_reg = port_s;
        D_RDATA_ACK:
        begin
          next_r.master_ack = ~sda_s;
          // Capture clears the alert; a change just before this rising edge is absorbed
          next_r.in_reg = port_s;
        end
        default:
          next_r.got = r.got;
      endcase
    end
    else if (scl_fall)
    begin
      next_r.got = 1'b0;
      case (r.st)
        D_ADDR:
          if (r.got)
          begin
            if (r.sh[7:1] == {ADDR_FIXED, addr_s})
            begin
              next_r.sda_oe_n = 1'b0;
              next_r.rw = r.sh[0];
              next_r.selected = 1'b1;
              next_r.st = D_ADDR_ACK;
            end
            else
              next_r.st = D_WAIT;
          end
        D_CMD:
          if (r.got)
          begin
            next_r.cmd = r.sh[1:0];
            next_r.sda_oe_n = 1'b0;
            next_r.st = D_CMD_ACK;
          end
        D_WDATA:
          if (r.got)
          begin
            // Same register takes every byte; input register ignores writes
            case (r.cmd)
              REG_OUTPUT: next_r.out_reg = r.sh;
              REG_POLARITY: next_r.pol_reg = r.sh;
              REG_CONFIG: next_r.cfg_reg = r.sh;
              default: next_r.out_reg = r.out_reg;
            endcase
            next_r.sda_oe_n = 1'b0;
            next_r.st = D_WDATA_ACK;
          end
        D_ADDR_ACK:
        begin
          next_r.bitc = '0;
          if (r.rw)
          begin
            next_r.tx = read_reg(r);
            next_r.sda_oe_n = next_r.tx[7];
            next_r.st = D_RDATA;
          end
          else
          begin
            next_r.sda_oe_n = 1'b1;
            next_r.st = D_CMD;
          end
        end
        D_CMD_ACK, D_WDATA_ACK:
        begin
          next_r.bitc = '0;
          next_r.sda_oe_n = 1'b1;
          next_r.st = D_WDATA;
        end
        D_RDATA:
          if (r.got)
          begin
            next_r.sda_oe_n = 1'b1;
            next_r.st = D_RDATA_ACK;
          end
          else
          begin
            next_r.tx = {r.tx[6:0], 1'b0};
            next_r.sda_oe_n = r.tx[6];
          end
        D_RDATA_ACK:
        begin
          next_r.bitc = '0;
          if (r.master_ack)
          begin
            next_r.tx = read_reg(r);
            next_r.sda_oe_n = next_r.tx[7];
            next_r.st = D_RDATA;
          end
          else
          begin
            next_r.sda_oe_n = 1'b1;
            next_r.st = D_WAIT;
          end
        end
        default:
          next_r.sda_oe_n = 1'b1;
      endcase
    end
    // Alert: input-mode pins differing from the last capture
    next_r.int_oe_n = ~|((port_s ^ r.in_reg) & r.cfg_reg)
                      | ~r.primed;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= DEV_RST;
    else
      r <= next_r;
  end

  // Driven level follows the enable, so the pins only ever pull low
  assign bus.d_sda_oe_n = r.sda_oe_n;
  assign bus.d_sda_o = r.sda_oe_n;
  assign bus.d_int_oe_n = r.int_oe_n;
  assign bus.d_int_o = r.int_oe_n;
  assign port_o = r.out_reg;
  assign port_oe_n = r.cfg_reg;
endmodule

`default_nettype wire

// *** pxe_pkg.sv ***
// Notes on behaviour
// - Input pin edge raises the change alert
// - Pin back to old level withdraws alert
// - Port read clears alert at ack bit
// - Stop clears alert once SDA rises
// - Change just before ack rising edge may be lost
// - Every change after clearing alerts again
// - Other slaves' traffic leaves alert untouched
// - Output pins never raise an alert
// - Output to input switch may alert falsely
// - Alert pin only pulls low, open drain
// - Write: address, command byte, then data
// - Any number of data bytes per write
// - Read: command, restart, address with read bit
// - Restart keeps the selected register
// - Read captures pins at ack rising edge
// - Endless read bytes, master nacks the last
// - Stop anywhere abandons the transfer cleanly
// - Two low command bits pick the register
// - Command byte kept until a new one
// - Answer addresses 0x38 to 0x3f via pins
// - Writes to input register are ignored
`default_nettype none

package pxe_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CORE_CLK_NS = 50;
  localparam int SCL_QUARTER_NS = 625;
  // Least time, so round up
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam logic [7:0] SCL_QUARTER_LAST = 8'(SCL_QUARTER_CYC - 1);

  // ------------------------------------------------------------
  // Device map
  // ------------------------------------------------------------
  typedef logic [7:0] pxe_byte_t;
  localparam logic [3:0] ADDR_FIXED = 4'h7;
  localparam logic [1:0] REG_INPUT = 2'h0;
  localparam logic [1:0] REG_OUTPUT = 2'h1;
  localparam logic [1:0] REG_POLARITY = 2'h2;
  localparam logic [1:0] REG_CONFIG = 2'h3;
  localparam pxe_byte_t OUTPUT_RST = 8'hff;
  localparam pxe_byte_t POLARITY_RST = 8'h00;
  localparam pxe_byte_t CONFIG_RST = 8'hff;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] FRAME_LAST = 4'h8;

  // ------------------------------------------------------------
  // Controller registers, APB
  // ------------------------------------------------------------
  typedef logic [7:0] pxe_paddr_t;
  localparam pxe_paddr_t OFS_CMD = 8'h00;
  localparam pxe_paddr_t OFS_STATUS = 8'h04;
  localparam int OP_LSB = 0;
  localparam int DATA_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_ACK = 1;
  localparam int ST_ALERT = 2;
  localparam logic [2:0] OP_START = 3'h1;
  localparam logic [2:0] OP_STOP = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_READ_ACK = 3'h4;
  localparam logic [2:0] OP_READ_NACK = 3'h5;

  typedef enum logic [3:0] {D_IDLE, D_ADDR, D_ADDR_ACK, D_CMD, D_CMD_ACK, D_WDATA, D_WDATA_ACK,
                            D_RDATA, D_RDATA_ACK, D_WAIT} pxe_dev_st_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_STOP, M_BITS} pxe_mst_st_t;

endpackage

`default_nettype wire

// *** pxe_i2c_if.sv ***
`default_nettype none

// ------------------------------------------------------------
// Two-wire link plus alert line; wires resolve as pulled up
// ------------------------------------------------------------
interface pxe_i2c_if;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic d_int_o;
  logic d_int_oe_n;
  logic scl;
  logic sda;
  logic int_n;

  // A released line floats high through its pull-up
  assign scl = m_scl_oe_n | m_scl_o;
  assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);
  assign int_n = d_int_oe_n | d_int_o;

  modport device (input scl, input sda, output d_sda_o, output d_sda_oe_n, output d_int_o, output d_int_oe_n);
  modport master (input scl, input sda, input int_n, output m_scl_o, output m_scl_oe_n, output m_sda_o,
                  output m_sda_oe_n);
endinterface

`default_nettype wire

// *** pxe_sync.sv ***
`default_nettype none

// ------------------------------------------------------------
// Two-flop synchroniser; only the second stage is read
// ------------------------------------------------------------
module pxe_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pxe_sync_t;

  pxe_sync_t r;
  pxe_sync_t next_r;

  // Shift chain
  always_comb
  begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  // Idle bus lines are high, so reset to ones
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= '1;
    else
      r <= next_r;
  end

  assign q = r.s2;
endmodule

`default_nettype wire

// *** pxe_master.sv ***
`default_nettype none

module pxe_master (
  input wire logic core_clk,
  input wire logic reset_n,
  pxe_i2c_if.master bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pxe_pkg::pxe_paddr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import pxe_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    pxe_mst_st_t st;
    logic [1:0] ph;
    logic [7:0] tick;
    logic [3:0] bitn;
    logic [8:0] tx;
    logic [8:0] rx;
    logic busy;
    logic scl_oe_n;
    logic sda_oe_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pxe_mst_state_t;

  localparam pxe_mst_state_t MST_RST = '{st: M_IDLE, scl_oe_n: 1'b1, sda_oe_n: 1'b1, default: '0};

  pxe_mst_state_t r;
  pxe_mst_state_t next_r;
  logic sda_s;
  logic alert_n_s;
  logic qtick;
  logic mapped;
  logic [2:0] op;

  pxe_sync #(.W(2)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .d({bus.sda, bus.int_n}),
    .q({sda_s, alert_n_s})
  );

  assign qtick = (r.tick == SCL_QUARTER_LAST);
  assign mapped = (paddr == OFS_CMD) || (paddr == OFS_STATUS);
  assign op = pwdata[OP_LSB +: 3];

  // ------------------------------------------------------------
  // Next state: APB slave and bit engine
  // ------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.tick = (qtick || !r.busy) ? '0 : r.tick + 8'h1;
    // Setup cycle loads the answer so access completes with no wait
    next_r.pready = psel & ~penable;
    if (psel && !penable)
    begin
      next_r.pslverr = ~mapped;
      next_r.prdata = '0;
      if (paddr == OFS_STATUS)
      begin
        next_r.prdata[ST_BUSY] = r.busy;
        next_r.prdata[ST_ACK] = ~r.rx[0];
        next_r.prdata[ST_ALERT] = ~alert_n_s;
        next_r.prdata[DATA_LSB +: 8] = r.rx[8:1];
      end
    end
    // An order written while busy is dropped
    if (psel && penable && r.pready && pwrite && paddr == OFS_CMD && !r.busy)
    begin
      next_r.ph = '0;
      next_r.bitn = '0;
      next_r.busy = 1'b1;
      case (op)
        OP_START: next_r.st = M_START;
        OP_STOP: next_r.st = M_STOP;
        OP_WRITE:
        begin
          next_r.st = M_BITS;
          next_r.tx = {pwdata[DATA_LSB +: 8], 1'b1};
        end
        OP_READ_ACK, OP_READ_NACK:
        begin
          next_r.st = M_BITS;
          next_r.tx = {8'hff, op == OP_READ_NACK};
        end
        default: next_r.busy = 1'b0;
      endcase
    end
    else if (r.busy && qtick)
    begin
      next_r.ph = r.ph + 2'h1;
      case (r.st)
        // Release SDA first so a restart also works from a held SCL
        M_START:
          case (r.ph)
            2'h0: next_r.sda_oe_n = 1'b1;
            2'h1: next_r.scl_oe_n = 1'b1;
            2'h2: next_r.sda_oe_n = 1'b0;
            default:
            begin
              next_r.scl_oe_n = 1'b0;
              next_r.busy = 1'b0;
              next_r.st = M_IDLE;
            end
          endcase
        M_STOP:
          case (r.ph)
            2'h0: next_r.sda_oe_n = 1'b0;
            2'h1: next_r.scl_oe_n = 1'b1;
            2'h2: next_r.sda_oe_n = 1'b1;
            default:
            begin
              next_r.busy = 1'b0;
              next_r.st = M_IDLE;
            end
          endcase
        M_BITS:
          case (r.ph)
            2'h0: next_r.sda_oe_n = r.tx[8];
            2'h1: next_r.scl_oe_n = 1'b1;
            2'h2: next_r.rx = {r.rx[7:0], sda_s};
            default:
            begin
              next_r.scl_oe_n = 1'b0;
              next_r.tx = {r.tx[7:0], 1'b1};
              next_r.bitn = r.bitn + 4'h1;
              if (r.bitn == FRAME_LAST)
              begin
                next_r.busy = 1'b0;
                next_r.st = M_IDLE;
              end
            end
          endcase
        default:
          next_r.busy = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= MST_RST;
    else
      r <= next_r;
  end

  assign bus.m_scl_oe_n = r.scl_oe_n;
  assign bus.m_scl_o = r.scl_oe_n;
  assign bus.m_sda_oe_n = r.sda_oe_n;
  assign bus.m_sda_o = r.sda_oe_n;
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
endmodule

`default_nettype wire

// *** pxe_assertions.sv ***
`default_nettype none

module pxe_assertions (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic int_n,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n,
  input wire logic d_int_o,
  input wire logic d_int_oe_n,
  input wire pxe_pkg::pxe_byte_t port_i,
  input wire pxe_pkg::pxe_byte_t port_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import pxe_pkg::*;

  // ------------------------------------------------------------
  // Cycles since each cause of an alert change
  // ------------------------------------------------------------
  logic [3:0] pin_age, clk_age, stop_age;
  pxe_byte_t seen_pins;
  logic past_scl, past_sda;

  function automatic logic [3:0] next_age(input logic [3:0] a);
    return (a == 4'hf) ? a : a + 4'h1;
  endfunction

  // Saturating ages; output pins are masked, so they never count as a cause
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_age <= 4'h0;
      clk_age <= 4'h0;
      stop_age <= 4'h0;
      seen_pins <= 8'h00;
      past_scl <= 1'b1;
      past_sda <= 1'b1;
    end
    else
    begin
      seen_pins <= port_i & port_oe_n;
      past_scl <= scl;
      past_sda <= sda;
      pin_age <= ((port_i & port_oe_n) != seen_pins) ? 4'h0 : next_age(pin_age);
      clk_age <= (scl && !past_scl) ? 4'h0 : next_age(clk_age);
      stop_age <= (scl && sda && !past_sda) ? 4'h0 : next_age(stop_age);
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence stop_seq;
    scl && $rose(sda);
  endsequence
  sequence start_seq;
    scl && $fell(sda);
  endsequence
  sequence held_low;
    !d_sda_oe_n [*8];
  endsequence

  a_int_pulls_low: assert property (!d_int_oe_n |-> !d_int_o)
    else $error("alert line driven high");
  a_sda_pulls_low: assert property (!d_sda_oe_n |-> !d_sda_o)
    else $error("data line driven high");
  a_alert_raise_cause: assert property ($fell(int_n) |-> pin_age < 4'h8)
    else $error("alert raised without an input change");
  a_alert_drop_cause: assert property ($rose(int_n) |->
    pin_age < 4'h8 || clk_age < 4'h8 || stop_age < 4'h8)
    else $error("alert withdrawn without a cause");
  a_data_moves_low: assert property ($changed(d_sda_oe_n) |-> !scl && !$past(scl))
    else $error("device changed data while clock high");
  a_stop_frees_sda: assert property (stop_seq |=> d_sda_oe_n [*8])
    else $error("device holds data line after stop");
  a_start_frees_sda: assert property (start_seq |=> d_sda_oe_n [*8])
    else $error("device holds data line after start");
  a_ack_held_low: assert property ($fell(d_sda_oe_n) |-> held_low)
    else $error("device low bit too short");
endmodule

`default_nettype wire

// *** test_i2c_port_expander_slave_irq.sv ***
`default_nettype none

module test_i2c_port_expander_slave_irq;
  timeunit 1ns;
  timeprecision 1ps;
  import pxe_pkg::*;

  // ------------------------------------------------------------
  // Bench state and the two joined ends
  // ------------------------------------------------------------
  localparam pxe_byte_t DEV_W = {ADDR_FIXED, 3'h5, 1'b0};
  localparam pxe_byte_t DEV_R = {ADDR_FIXED, 3'h5, 1'b1};
  localparam pxe_byte_t OTHER_W = {ADDR_FIXED, 3'h6, 1'b0};
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  pxe_paddr_t paddr;
  logic [31:0] pwdata, prdata, st;
  pxe_byte_t port_i, port_o, port_oe_n;
  pxe_byte_t exp_regs [4];
  logic [2:0] sel;
  int num_errors, samples_checked;

  pxe_i2c_if pxe_i2c_if_i ();
  pxe_device pxe_device_i (.core_clk(core_clk), .reset_n(reset_n), .bus(pxe_i2c_if_i), .port_i(port_i),
    .port_o(port_o), .port_oe_n(port_oe_n), .addr_sel_bit0(sel[0]), .addr_sel_bit1(sel[1]), .addr_sel_bit2(sel[2]));
  pxe_master pxe_master_i (.core_clk(core_clk), .reset_n(reset_n), .bus(pxe_i2c_if_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  pxe_assertions pxe_assertions_i (.core_clk(core_clk), .reset_n(reset_n), .scl(pxe_i2c_if_i.scl),
    .sda(pxe_i2c_if_i.sda), .int_n(pxe_i2c_if_i.int_n), .d_sda_o(pxe_i2c_if_i.d_sda_o),
    .d_sda_oe_n(pxe_i2c_if_i.d_sda_oe_n), .d_int_o(pxe_i2c_if_i.d_int_o),
    .d_int_oe_n(pxe_i2c_if_i.d_int_oe_n), .port_i(port_i), .port_oe_n(port_oe_n));

  // Clock
  always #25 core_clk = ~core_clk;

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic wr, input pxe_paddr_t a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    st = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Issue a link operation and poll until the engine is idle
  task automatic op(input logic [2:0] code, input pxe_byte_t b);
    apb(1'b1, OFS_CMD, {16'h0, b, 5'h0, code});
    apb(1'b0, OFS_STATUS, 32'h0);
    while (st[ST_BUSY] === 1'b1)
      apb(1'b0, OFS_STATUS, 32'h0);
  endtask

  task automatic wb(input pxe_byte_t b, input logic ack);
    op(OP_WRITE, b);
    chk(32'(st[ST_ACK]), 32'(ack));
  endtask

  task automatic rd(input logic [2:0] code, input pxe_byte_t exp);
    op(code, 8'h00);
    chk(32'(st[15:8]), 32'(exp));
  endtask

  task automatic write_reg(input pxe_byte_t cmd, input pxe_byte_t d);
    op(OP_START, 8'h00);
    wb(DEV_W, 1'b1);
    wb(cmd, 1'b1);
    wb(d, 1'b1);
    op(OP_STOP, 8'h00);
  endtask

  // Command, restart, then a single byte closed by a nack
  task automatic read_reg(input pxe_byte_t cmd, input pxe_byte_t exp);
    op(OP_START, 8'h00);
    wb(DEV_W, 1'b1);
    wb(cmd, 1'b1);
    op(OP_START, 8'h00);
    wb(DEV_R, 1'b1);
    rd(OP_READ_NACK, exp);
    op(OP_STOP, 8'h00);
  endtask

  // Alert pipeline is a few cycles deep, eight leaves margin
  task automatic pins(input pxe_byte_t v);
    @(posedge core_clk);
    port_i <= v;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 23000 cycles
  initial
  begin
    repeat (70000) @(posedge core_clk);
    num_errors++;
    close_out();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    port_i = 8'h5c;
    sel = 3'h5;
    num_errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(32'(port_oe_n), 32'(CONFIG_RST));
    chk(32'(port_o), 32'(OUTPUT_RST));
    chk(32'(pxe_i2c_if_i.int_n), 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk({st[30:0], pslverr}, 32'h1);
    $display("Test reset done");
    op(OP_START, 8'h00);
    wb(DEV_W, 1'b1);
    wb(8'h03, 1'b1);
    wb(8'haa, 1'b1);
    wb(8'hf0, 1'b1);
    op(OP_STOP, 8'h00);
    chk(32'(port_oe_n), 32'hf0);
    write_reg(8'h01, 8'h05);
    chk(32'(port_o), 32'h05);
    write_reg(8'h00, 8'h55);
    exp_regs = '{8'h5c, 8'h05, POLARITY_RST, 8'hf0};
    for (int i = 0; i < 4; i++)
      read_reg(8'(i), exp_regs[i]);
    op(OP_START, 8'h00);
    wb(DEV_R, 1'b1);
    rd(OP_READ_ACK, 8'hf0);
    rd(OP_READ_NACK, 8'hf0);
    op(OP_STOP, 8'h00);
    $display("Test registers done");
    pins(8'h5d);
    chk(32'(pxe_i2c_if_i.int_n), 32'h1);
    pins(8'h7d);
    chk(32'(pxe_i2c_if_i.int_n), 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(st[ST_ALERT]), 32'h1);
    pins(8'h5d);
    chk(32'(pxe_i2c_if_i.int_n), 32'h1);
    pins(8'h7d);
    op(OP_START, 8'h00);
    wb(OTHER_W, 1'b0);
    op(OP_STOP, 8'h00);
    chk(32'(pxe_i2c_if_i.int_n), 32'h0);
    op(OP_START, 8'h00);
    wb(DEV_W, 1'b1);
    wb(8'h00, 1'b1);
    op(OP_START, 8'h00);
    wb(DEV_R, 1'b1);
    chk(32'(pxe_i2c_if_i.int_n), 32'h1);
    rd(OP_READ_ACK, 8'h7d);
    pins(8'h1d);
    chk(32'(pxe_i2c_if_i.int_n), 32'h0);
    rd(OP_READ_ACK, 8'h7d);
    chk(32'(pxe_i2c_if_i.int_n), 32'h1);
    rd(OP_READ_NACK, 8'h1d);
    op(OP_STOP, 8'h00);
    pins(8'h3d);
    chk(32'(pxe_i2c_if_i.int_n), 32'h0);
    op(OP_START, 8'h00);
    wb(DEV_W, 1'b1);
    op(OP_STOP, 8'h00);
    repeat (8) @(posedge core_clk);
    chk(32'(pxe_i2c_if_i.int_n), 32'h1);
    write_reg(8'h02, 8'h0f);
    read_reg(8'h00, 8'h32);
    $display("Test alert done");
    close_out();
  end
endmodule

`default_nettype wire
